// File: rtl/pafs_bank_decode.sv
// Bank 00 mirror decoder for the top memory image
`timescale 1ns/1ps
`default_nettype none
module pafs_bank_decode (
    input wire logic [23:0] cpu_addr,
    output logic [23:0] phys_addr,
    output logic mirror_hit
);
    // ***************************************************************
    // Decode
    // ***************************************************************
    logic [7:0] bank;
    logic [15:0] offs;
    assign bank = cpu_addr[23:16];
    assign offs = cpu_addr[15:0];
    // Low 16K of bank FF never shows in bank 00
    assign mirror_hit = (bank == pafs_pkg::BANK_LOW) &&
                        (offs >= pafs_pkg::MIRROR_BASE);
    // Mirrored accesses land in bank FF
    assign phys_addr = mirror_hit ? {pafs_pkg::BANK_TOP, offs} : cpu_addr;
endmodule
`default_nettype wire

// File: rtl/pafs_pkg.sv
// Shared constants for the port alternate function selector
package pafs_pkg;
    // ***************************************************************
    // Widths and reset values
    // ***************************************************************
    localparam int PORT_W = 8;
    localparam int ADDR_W = 24;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam int CLK_HALF_DEF = 1;  // Machine clock is core_clk / 2

    // ***************************************************************
    // Port 3 bit positions
    // ***************************************************************
    localparam int P3_ALE = 0;
    localparam int P3_RD = 1;
    localparam int P3_WRL = 2;
    localparam int P3_WRH = 3;
    localparam int P3_HRQ = 4;
    localparam int P3_HAK = 5;
    localparam int P3_RDY = 6;
    localparam int P3_CLK = 7;

    // ***************************************************************
    // Port 4 bit positions (serial channel 0)
    // ***************************************************************
    localparam int P4_SIN = 0;
    localparam int P4_SOT = 1;
    localparam int P4_SCK = 2;

    // ***************************************************************
    // Bank mirroring
    // ***************************************************************
    localparam logic [7:0] BANK_LOW = 8'h00;
    localparam logic [7:0] BANK_TOP = 8'hFF;
    localparam logic [15:0] MIRROR_BASE = 16'h4000;
endpackage

// File: rtl/pafs_top.sv
// Pin function selector for ports 0 to 4 and bank mirror
`timescale 1ns/1ps
`default_nettype none
module pafs_top #(
    parameter int CLK_HALF = pafs_pkg::CLK_HALF_DEF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    // General-purpose data and direction, ports 0 to 4
    input wire logic [7:0] port0_data,
    input wire logic [7:0] port1_data,
    input wire logic [7:0] port2_data,
    input wire logic [7:0] port3_data,
    input wire logic [7:0] port4_data,
    input wire logic [7:0] port0_direction,
    input wire logic [7:0] port1_direction,
    input wire logic [7:0] port2_direction,
    input wire logic [7:0] port3_direction,
    input wire logic [7:0] port4_direction,
    input wire logic [7:0] port0_pullup_select,
    input wire logic [7:0] port1_pullup_select,
    input wire logic [7:0] port4_opendrain_select,
    // Bus configuration
    input wire logic ext_bus_mode,
    input wire logic bus_16bit_mode,
    input wire logic [7:0] upper_address_pin_select,
    input wire logic write_strobe_enable_bit,
    input wire logic hold_pins_enable_bit,
    input wire logic ready_pin_enable_bit,
    input wire logic clock_out_enable_bit,
    // From the bus controller
    input wire logic [7:0] muxed_lower_lines,
    input wire logic [7:0] muxed_upper_lines,
    input wire logic bus_data_oe,
    input wire logic [7:0] upper_address_bits,
    input wire logic address_latch_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_low_byte_n,
    input wire logic write_strobe_high_byte_n,
    input wire logic hold_grant,
    input wire logic [23:0] cpu_addr,
    // From serial channel 0
    input wire logic uart0_rx_active,
    input wire logic uart0_serial_out,
    input wire logic uart0_tx_enable,
    input wire logic uart0_clock_out,
    input wire logic uart0_clock_oe,
    // Pin inputs
    input wire logic [7:0] port0_pins_in,
    input wire logic [7:0] port1_pins_in,
    input wire logic [7:0] port2_pins_in,
    input wire logic [7:0] port3_pins_in,
    input wire logic [7:0] port4_pins_in,
    // Pin outputs and enables
    output logic [7:0] port0_pins_out,
    output logic [7:0] port1_pins_out,
    output logic [7:0] port2_pins_out,
    output logic [7:0] port3_pins_out,
    output logic [7:0] port4_pins_out,
    output logic [7:0] port0_pins_oe,
    output logic [7:0] port1_pins_oe,
    output logic [7:0] port2_pins_oe,
    output logic [7:0] port3_pins_oe,
    output logic [7:0] port4_pins_oe,
    output logic [7:0] port0_pullup_en,
    output logic [7:0] port1_pullup_en,
    // Readback of pin levels
    output logic [7:0] port0_read,
    output logic [7:0] port1_read,
    output logic [7:0] port2_read,
    output logic [7:0] port3_read,
    output logic [7:0] port4_read,
    // Toward the bus controller and serial channel
    output logic [15:0] bus_data_in,
    output logic hold_request_input,
    output logic bus_wait_ready_input,
    output logic uart0_serial_in,
    output logic uart0_serial_clock,
    output logic [23:0] phys_addr,
    output logic mirror_hit
);
    // ***************************************************************
    // Elaboration checks
    // ***************************************************************
    if (CLK_HALF < 1) begin : g_bad_half
        $error("CLK_HALF must be at least 1");
    end

    // ***************************************************************
    // Helpers
    // ***************************************************************
    // Per-bit select between alternate and general-purpose values
    function automatic logic [7:0] pafs_mux(
        input logic [7:0] sel,
        input logic [7:0] alt,
        input logic [7:0] gp
    );
        pafs_mux = (sel & alt) | (~sel & gp);
    endfunction

    // ***************************************************************
    // Machine clock divider
    // ***************************************************************
    localparam int CW = (CLK_HALF > 1) ? $clog2(CLK_HALF) : 1;
    localparam logic [CW-1:0] HALF_LAST = CW'(CLK_HALF - 1);
    logic [CW-1:0] div_cnt_r;
    logic [CW-1:0] div_cnt_nxt;
    logic div_tick;
    logic mclk_r;

    assign div_tick = (div_cnt_r == HALF_LAST);
    assign div_cnt_nxt = div_tick ? '0 : div_cnt_r + CW'(1);

    // Free-running so pin 37 shows a steady clock once enabled
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_cnt_r <= '0;
            mclk_r <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            if (div_tick) begin
                mclk_r <= ~mclk_r;
            end
        end
    end

    // ***************************************************************
    // Mode qualifiers
    // ***************************************************************
    logic bus16;
    logic wrl_sel;
    logic wrh_sel;
    logic hold_sel;
    logic rdy_sel;
    logic clk_sel;
    assign bus16 = ext_bus_mode & bus_16bit_mode;
    assign wrl_sel = ext_bus_mode & write_strobe_enable_bit;
    assign wrh_sel = bus16 & write_strobe_enable_bit;
    assign hold_sel = ext_bus_mode & hold_pins_enable_bit;
    assign rdy_sel = ext_bus_mode & ready_pin_enable_bit;
    assign clk_sel = ext_bus_mode & clock_out_enable_bit;

    // ***************************************************************
    // Ports 0 and 1: multiplexed address/data
    // ***************************************************************
    logic [7:0] p0_sel;
    logic [7:0] p1_sel;
    logic [7:0] p0_out_nxt;
    logic [7:0] p1_out_nxt;
    logic [7:0] p0_oe_nxt;
    logic [7:0] p1_oe_nxt;
    // Whole port taken over; controller decides address/data drive
    assign p0_sel = {8{ext_bus_mode}};
    assign p1_sel = {8{bus16}};
    assign p0_out_nxt = pafs_mux(p0_sel, muxed_lower_lines,
                                 port0_data);
    assign p1_out_nxt = pafs_mux(p1_sel, muxed_upper_lines,
                                 port1_data);
    assign p0_oe_nxt = pafs_mux(p0_sel, {8{bus_data_oe}},
                                port0_direction);
    assign p1_oe_nxt = pafs_mux(p1_sel, {8{bus_data_oe}},
                                port1_direction);

    // Pull-ups only on pins set as inputs
    logic [7:0] pu0_nxt;
    logic [7:0] pu1_nxt;
    assign pu0_nxt = port0_pullup_select & ~port0_direction;
    assign pu1_nxt = port1_pullup_select & ~port1_direction;

    // ***************************************************************
    // Port 2: upper address, chosen pin by pin
    // ***************************************************************
    logic [7:0] p2_sel;
    logic [7:0] p2_out_nxt;
    logic [7:0] p2_oe_nxt;
    assign p2_sel = {8{ext_bus_mode}} & upper_address_pin_select;
    assign p2_out_nxt = pafs_mux(p2_sel, upper_address_bits, port2_data);
    assign p2_oe_nxt = pafs_mux(p2_sel, 8'hFF, port2_direction);

    // ***************************************************************
    // Port 3: bus strobes, hold, ready, clock
    // ***************************************************************
    logic [7:0] p3_sel;
    logic [7:0] p3_alt_v;
    logic [7:0] p3_alt_d;
    logic [7:0] p3_out_nxt;
    logic [7:0] p3_oe_nxt;
    // Select vector, one bit per pin function
    assign p3_sel = {clk_sel, rdy_sel, hold_sel, hold_sel,
                     wrh_sel, wrl_sel, ext_bus_mode,
                     ext_bus_mode};
    // Alternate values; read and write strobes already active low from controller, latch strobe active high
    assign p3_alt_v = {mclk_r,
                       1'b0,
                       ~hold_grant,
                       1'b0,
                       write_strobe_high_byte_n,
                       write_strobe_low_byte_n,
                       read_strobe_n,
                       address_latch_strobe};
    // Request and ready pins are inputs: never driven when selected
    assign p3_alt_d = 8'hAF;
    assign p3_out_nxt = pafs_mux(p3_sel, p3_alt_v, port3_data);
    assign p3_oe_nxt = pafs_mux(p3_sel, p3_alt_d, port3_direction);

    // ***************************************************************
    // Port 4: serial channel 0 and open drain
    // ***************************************************************
    logic [7:0] p4_sel;
    logic [7:0] p4_alt_v;
    logic [7:0] p4_alt_d;
    logic [7:0] p4_val;
    logic [7:0] p4_drv;
    logic [7:0] p4_od;
    logic [7:0] p4_out_nxt;
    logic [7:0] p4_oe_nxt;
    // Receive forces pin 40 quiet; TX and clock take their pins
    assign p4_sel = {5'h00, uart0_clock_oe, uart0_tx_enable,
                     uart0_rx_active};
    assign p4_alt_v = {5'h00, uart0_clock_out,
                       uart0_serial_out, 1'b0};
    assign p4_alt_d = 8'h06;
    assign p4_val = pafs_mux(p4_sel, p4_alt_v, port4_data);
    assign p4_drv = pafs_mux(p4_sel, p4_alt_d, port4_direction);
    // Open drain pulls low only; dead while the pin is an input
    assign p4_od = port4_opendrain_select & port4_direction;
    assign p4_out_nxt = p4_val & ~p4_od;
    assign p4_oe_nxt = p4_drv & ~(p4_od & p4_val);

    // ***************************************************************
    // Bank mirror decoder
    // ***************************************************************
    logic [23:0] dec_addr;
    logic dec_hit;
    pafs_bank_decode u_dec (
        .cpu_addr(cpu_addr),
        .phys_addr(dec_addr),
        .mirror_hit(dec_hit)
    );

    // ***************************************************************
    // Output registers
    // ***************************************************************
    // Registered pins avoid glitches on strobes as modes change
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            port0_pins_out <= pafs_pkg::PORT_RST;
            port1_pins_out <= pafs_pkg::PORT_RST;
            port2_pins_out <= pafs_pkg::PORT_RST;
            port3_pins_out <= pafs_pkg::PORT_RST;
            port4_pins_out <= pafs_pkg::PORT_RST;
            port0_pins_oe <= pafs_pkg::PORT_RST;
            port1_pins_oe <= pafs_pkg::PORT_RST;
            port2_pins_oe <= pafs_pkg::PORT_RST;
            port3_pins_oe <= pafs_pkg::PORT_RST;
            port4_pins_oe <= pafs_pkg::PORT_RST;
            port0_pullup_en <= pafs_pkg::PORT_RST;
            port1_pullup_en <= pafs_pkg::PORT_RST;
        end else begin
            port0_pins_out <= p0_out_nxt;
            port1_pins_out <= p1_out_nxt;
            port2_pins_out <= p2_out_nxt;
            port3_pins_out <= p3_out_nxt;
            port4_pins_out <= p4_out_nxt;
            port0_pins_oe <= p0_oe_nxt;
            port1_pins_oe <= p1_oe_nxt;
            port2_pins_oe <= p2_oe_nxt;
            port3_pins_oe <= p3_oe_nxt;
            port4_pins_oe <= p4_oe_nxt;
            port0_pullup_en <= pu0_nxt;
            port1_pullup_en <= pu1_nxt;
        end
    end

    // ***************************************************************
    // Input capture
    // ***************************************************************
    logic hrq_nxt;
    logic rdy_nxt;
    // Inactive defaults keep the controller running when unselected
    assign hrq_nxt = hold_sel & port3_pins_in[pafs_pkg::P3_HRQ];
    assign rdy_nxt = rdy_sel ? port3_pins_in[pafs_pkg::P3_RDY]
                             : 1'b1;

    // Pin levels stay readable under any alternate function
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            port0_read <= pafs_pkg::PORT_RST;
            port1_read <= pafs_pkg::PORT_RST;
            port2_read <= pafs_pkg::PORT_RST;
            port3_read <= pafs_pkg::PORT_RST;
            port4_read <= pafs_pkg::PORT_RST;
            bus_data_in <= 16'h0000;
            hold_request_input <= 1'b0;
            bus_wait_ready_input <= 1'b1;
            uart0_serial_in <= 1'b1;
            uart0_serial_clock <= 1'b1;
        end else begin
            port0_read <= port0_pins_in;
            port1_read <= port1_pins_in;
            port2_read <= port2_pins_in;
            port3_read <= port3_pins_in;
            port4_read <= port4_pins_in;
            bus_data_in <= {port1_pins_in, port0_pins_in};
            hold_request_input <= hrq_nxt;
            bus_wait_ready_input <= rdy_nxt;
            uart0_serial_in <= port4_pins_in[pafs_pkg::P4_SIN];
            uart0_serial_clock <= port4_pins_in[pafs_pkg::P4_SCK];
        end
    end

    // ***************************************************************
    // Decoder output registers
    // ***************************************************************
    // One cycle of latency on the mapped address
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phys_addr <= 24'h000000;
            mirror_hit <= 1'b0;
        end else begin
            phys_addr <= dec_addr;
            mirror_hit <= dec_hit;
        end
    end
endmodule
`default_nettype wire

// File: tb/pafs_assertions.sv
// Port-level assertions for the pin function selector
`timescale 1ns/1ps
`default_nettype none
module pafs_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] port0_direction,
    input wire logic [7:0] port0_pullup_select,
    input wire logic [7:0] port0_pullup_en,
    input wire logic ext_bus_mode,
    input wire logic bus_16bit_mode,
    input wire logic [7:0] muxed_lower_lines,
    input wire logic [7:0] muxed_upper_lines,
    input wire logic [7:0] port0_pins_out,
    input wire logic [7:0] port1_pins_out,
    input wire logic [7:0] upper_address_bits,
    input wire logic [7:0] upper_address_pin_select,
    input wire logic [7:0] port2_pins_out,
    input wire logic [7:0] port3_pins_out,
    input wire logic [7:0] port3_data,
    input wire logic address_latch_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_enable_bit,
    input wire logic write_strobe_low_byte_n,
    input wire logic hold_pins_enable_bit,
    input wire logic hold_grant,
    input wire logic ready_pin_enable_bit,
    input wire logic bus_wait_ready_input,
    input wire logic uart0_rx_active,
    input wire logic [7:0] port4_pins_oe,
    input wire logic [23:0] cpu_addr,
    input wire logic [23:0] phys_addr,
    input wire logic mirror_hit
);
    // ***********************************************************
    // One-cycle relations; the first edge after reset is skipped
    // ***********************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    pullup_out_a: assert property ($past(rst_n) |->
        port0_pullup_en == $past(port0_pullup_select & ~port0_direction))
        else $error("pull-up enable wrong");
    lower_bus_a: assert property ($past(rst_n && ext_bus_mode) |->
        port0_pins_out == $past(muxed_lower_lines))
        else $error("port 0 not carrying lower bus");
    upper_bus_a: assert property ($past(rst_n && ext_bus_mode &&
        bus_16bit_mode) |-> port1_pins_out == $past(muxed_upper_lines))
        else $error("port 1 not carrying upper bus");
    addr_pins_a: assert property ($past(rst_n && ext_bus_mode) |->
        ((port2_pins_out ^ $past(upper_address_bits))
        & $past(upper_address_pin_select)) == 8'h00)
        else $error("port 2 address pin wrong");
    bus_strobes_a: assert property ($past(rst_n && ext_bus_mode) |->
        port3_pins_out[1:0] == $past({read_strobe_n, address_latch_strobe}))
        else $error("latch or read strobe wrong");
    low_write_a: assert property ($past(rst_n) |-> port3_pins_out[2] ==
        ($past(ext_bus_mode && write_strobe_enable_bit)
        ? $past(write_strobe_low_byte_n) : $past(port3_data[2])))
        else $error("low write strobe pin wrong");
    hold_ack_a: assert property ((ext_bus_mode && hold_pins_enable_bit
        && hold_grant)[*2] |-> !port3_pins_out[5])
        else $error("hold acknowledge not low");
    ready_idle_a: assert property ($past(rst_n) &&
        !$past(ext_bus_mode && ready_pin_enable_bit) |-> bus_wait_ready_input)
        else $error("ready low while unselected");
    rx_undriven_a: assert property ($past(rst_n && uart0_rx_active) |->
        !port4_pins_oe[0])
        else $error("serial input pin driven");
    bank_mirror_a: assert property ($past(rst_n) |->
        mirror_hit == ($past(cpu_addr[23:16]) == 8'h00
        && $past(cpu_addr[15:0]) >= 16'h4000))
        else $error("mirror decision wrong");
endmodule
bind pafs_top pafs_checker chk (.*);
`default_nettype wire

// File: tb/pafs_bus_mem.sv
// External memory on the multiplexed bus, partner of the selector
`timescale 1ns/1ps
`default_nettype none
module pafs_bus_mem (
    input wire logic core_clk,
    input wire logic [15:0] bus_out,
    input wire logic [15:0] bus_oe,
    input wire logic [15:0] pull_hi,
    input wire logic ale,
    input wire logic rd_n,
    output logic [15:0] bus_in
);
    logic [15:0] addr_r;
    logic [15:0] last_r;
    logic [15:0] rdata;
    logic [15:0] far;
    // Data is a fixed scramble of the latched address
    assign rdata = addr_r ^ 16'h3C3C;
    // Undriven lines return read data while rd_n is low, else pulled high or flipping, never stale
    assign far = !rd_n ? rdata : (pull_hi | ~last_r);
    assign bus_in = (bus_oe & bus_out) | (~bus_oe & far);
    // Address captured from both bytes while the latch strobe is high
    always_ff @(posedge core_clk) begin
        if (ale) begin
            addr_r <= bus_out;
        end
        last_r <= bus_in;
    end
endmodule
`default_nettype wire

// File: tb/pafs_top_bench.sv
// Self-checking bench for the pin function selector
`timescale 1ns/1ps
`default_nettype none
module port_alternate_function_select_bench;
    logic core_clk, rst_n;
    logic [7:0] port0_data, port1_data, port2_data, port3_data, port4_data;
    logic [7:0] port0_direction, port1_direction, port2_direction;
    logic [7:0] port3_direction, port4_direction, port4_opendrain_select;
    logic [7:0] port0_pullup_select, port1_pullup_select;
    logic [7:0] upper_address_pin_select, upper_address_bits;
    logic ext_bus_mode, bus_16bit_mode, write_strobe_enable_bit;
    logic hold_pins_enable_bit, ready_pin_enable_bit, clock_out_enable_bit;
    logic [7:0] muxed_lower_lines, muxed_upper_lines;
    logic bus_data_oe, address_latch_strobe, read_strobe_n, hold_grant;
    logic write_strobe_low_byte_n, write_strobe_high_byte_n;
    logic [23:0] cpu_addr, phys_addr;
    logic uart0_rx_active, uart0_serial_out, uart0_tx_enable;
    logic uart0_clock_out, uart0_clock_oe, mirror_hit, clk_prev;
    wire [7:0] port0_pins_in, port1_pins_in;
    wire [7:0] port2_pins_in, port3_pins_in, port4_pins_in;
    logic [7:0] port0_pins_out, port1_pins_out, port2_pins_out;
    logic [7:0] port3_pins_out, port4_pins_out, port0_pins_oe;
    logic [7:0] port1_pins_oe, port2_pins_oe, port3_pins_oe, port4_pins_oe;
    logic [7:0] port0_pullup_en, port1_pullup_en, port0_read, port1_read;
    logic [7:0] port2_read, port3_read, port4_read, drv2, drv3, drv4;
    logic [15:0] bus_data_in;
    logic hold_request_input, bus_wait_ready_input, uart0_serial_in;
    logic uart0_serial_clock;
    int n_errors = 0;
    int checks = 0;
    typedef struct packed {
        logic [5:0] cfg;
        logic [7:0] sel, e3o, e3e, e2;
        logic [1:0] e10;
    } pafs_row_s;
    // Mode bits {ext,16,wre,hde,rye,cke}, select, expected pins
    pafs_row_s rows [7] = '{'{6'h00, 8'hFF, 8'h08, 8'hFF, 8'h3C, 2'h0},
        '{6'h20, 8'h00, 8'h0B, 8'hFF, 8'h3C, 2'h1},
        '{6'h28, 8'h0F, 8'h0F, 8'hFF, 8'h3F, 2'h1},
        '{6'h38, 8'hF0, 8'h07, 8'hFF, 8'hFC, 2'h3},
        '{6'h30, 8'h00, 8'h0B, 8'hFF, 8'h3C, 2'h3},
        '{6'h07, 8'h00, 8'h08, 8'hFF, 8'h3C, 2'h0},
        '{6'h27, 8'h81, 8'h2B, 8'hAF, 8'hBD, 2'h1}};
    logic [23:0] addrs [5] = '{24'h003FFF, 24'h004000, 24'h00FFFF,
        24'hFF3FFF, 24'h018000};
    // ***********************************************************
    // Design, bus partner and the bench's own pin drivers
    // ***********************************************************
    pafs_top uut (.*);
    pafs_bus_mem mem (.core_clk, .bus_out({port1_pins_out, port0_pins_out}),
        .bus_oe({port1_pins_oe, port0_pins_oe}),
        .pull_hi({port1_pullup_en, port0_pullup_en}),
        .ale(port3_pins_out[0]), .rd_n(port3_pins_out[1]),
        .bus_in({port1_pins_in, port0_pins_in}));
    // Requests on pins 34 and 36 come from drv3
    assign port2_pins_in = (port2_pins_oe & port2_pins_out) | ~port2_pins_oe & drv2;
    assign port3_pins_in = (port3_pins_oe & port3_pins_out) | ~port3_pins_oe & drv3;
    assign port4_pins_in = (port4_pins_oe & port4_pins_out) | ~port4_pins_oe & drv4;
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [23:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Outputs lag one edge; pin feedback needs one more
    task automatic settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog so a hang still reaches the verdict
    initial begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        end_of_test();
    end
    initial begin
        {port0_data, port1_data, port2_data, port3_data, port4_data} = '0;
        {port0_direction, port1_direction, port2_direction} = '0;
        {port3_direction, port4_direction, port4_opendrain_select} = '0;
        {port0_pullup_select, port1_pullup_select, cpu_addr} = '0;
        {upper_address_pin_select, muxed_lower_lines, muxed_upper_lines} = '0;
        {ext_bus_mode, bus_16bit_mode, write_strobe_enable_bit} = '0;
        {hold_pins_enable_bit, ready_pin_enable_bit, clock_out_enable_bit} = '0;
        {bus_data_oe, address_latch_strobe, hold_grant, uart0_rx_active} = 4'h4;
        {uart0_serial_out, uart0_tx_enable, uart0_clock_out} = '0;
        {uart0_clock_oe, rst_n, write_strobe_high_byte_n} = '0;
        {read_strobe_n, write_strobe_low_byte_n} = 2'h3;
        upper_address_bits = 8'hFF;
        {drv2, drv3, drv4} = {8'h00, 8'h40, 8'h00};
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        settle();
        chk("ready idle", bus_wait_ready_input, 1'b1);
        // Mode table: strobes, address pins and bus byte enables
        @(posedge core_clk);
        {port0_direction, port1_direction} <= 16'h0F0F;
        {port2_direction, port3_direction} <= 16'hFFFF;
        {port2_data, port3_data, bus_data_oe} <= {8'h3C, 8'h08, 1'b1};
        foreach (rows[i]) begin
            @(posedge core_clk);
            {ext_bus_mode, bus_16bit_mode, write_strobe_enable_bit,
                hold_pins_enable_bit, ready_pin_enable_bit,
                clock_out_enable_bit} <= rows[i].cfg;
            upper_address_pin_select <= rows[i].sel;
            settle();
            chk("p3 out", port3_pins_out & 8'h7F, rows[i].e3o);
            chk("p3 oe", port3_pins_oe, rows[i].e3e);
            chk("p2 out", port2_pins_out, rows[i].e2);
            chk("p1 oe", port1_pins_oe, {8{rows[i].e10[1]}} | 8'h0F);
            chk("p0 oe", port0_pins_oe, {8{rows[i].e10[0]}} | 8'h0F);
        end
        $display("mode table done");
        // Machine clock on pin 37 flips every cycle
        for (int k = 0; k < 4; k++) begin
            clk_prev = port3_pins_out[7];
            @(posedge core_clk);
            #1;
            chk("mclk", port3_pins_out[7], !clk_prev);
        end
        $display("clock output done");
        // Read cycle through the partner, hold and ready pins
        @(posedge core_clk);
        {ext_bus_mode, bus_16bit_mode, address_latch_strobe} <= 3'h7;
        {muxed_upper_lines, muxed_lower_lines} <= 16'h1234;
        {hold_pins_enable_bit, ready_pin_enable_bit, hold_grant} <= 3'h7;
        drv3 <= 8'h10;
        settle();
        @(posedge core_clk);
        {address_latch_strobe, bus_data_oe, read_strobe_n} <= 3'h0;
        settle();
        chk("read data", bus_data_in, 16'h1234 ^ 16'h3C3C);
        chk("hold ack", port3_pins_out[5], 1'b0);
        chk("hold req", hold_request_input, 1'b1);
        chk("ready", bus_wait_ready_input, 1'b0);
        $display("bus read done");
        // Pull-ups only on pins set as inputs
        @(posedge core_clk);
        {ext_bus_mode, read_strobe_n} <= 2'h1;
        {port0_pullup_select, port0_direction} <= 16'hFF0F;
        {port1_pullup_select, port1_direction} <= 16'hAAFF;
        settle();
        chk("pu0", port0_pullup_en, 8'hF0);
        chk("pu1", port1_pullup_en, 8'h00);
        // Open drain: low drives, high releases, input never drives
        @(posedge core_clk);
        {port4_opendrain_select, port4_direction} <= 16'h0F05;
        port4_data <= 8'h01;
        settle();
        chk("od oe", port4_pins_oe, 8'h04);
        chk("od out", port4_pins_out & 8'h0F, 8'h00);
        // Serial pins: input undriven, output and clock when enabled
        @(posedge core_clk);
        {port4_opendrain_select, port4_direction, port4_data} <= 24'h00FF00;
        {uart0_rx_active, uart0_tx_enable, uart0_clock_oe} <= 3'h7;
        {uart0_serial_out, uart0_clock_out} <= 2'h1;
        settle();
        chk("uart oe", port4_pins_oe, 8'hFE);
        chk("uart out", port4_pins_out, 8'h04);
        chk("uart in", uart0_serial_in, 1'b0);
        @(posedge core_clk);
        {uart0_tx_enable, uart0_clock_oe, port4_direction} <= 10'h000;
        drv4 <= 8'h01;
        settle();
        chk("uart off", port4_pins_oe, 8'h00);
        chk("sck in", uart0_serial_clock, 1'b0);
        $display("port 4 done");
        // Bank 00 mirror of the top image, boundaries on both sides
        foreach (addrs[i]) begin
            @(posedge core_clk);
            cpu_addr <= addrs[i];
            settle();
            chk("phys", phys_addr, (addrs[i][23:16] == 8'h00 && addrs[i][15:0]
                >= 16'h4000) ? {8'hFF, addrs[i][15:0]} : addrs[i]);
        end
        $display("mirror done");
        end_of_test();
    end
endmodule
`default_nettype wire
